// file: hw/irq_code_consts.svh
// Interrupt codes, phase encodings and timing counts for the transfer interrupt encoder.
`ifndef IRQ_CODE_CONSTS_SVH
`define IRQ_CODE_CONSTS_SVH

`define CODE_DMA_PAR       8'h21
`define CODE_MPU_PAR       8'h22
`define CODE_SCSI_PAR      8'h24
`define CODE_SCSI_DMA_PAR  8'h25
`define CODE_SCSI_MPU_PAR  8'h26
`define CODE_OFFSET        8'h29
`define CODE_SHORT_PERIOD  8'h2A
`define CODE_OFFSET_SHORT  8'h2B
`define CODE_REQACK_TMO    8'h2C
`define CODE_BUS_FREE      8'h31
`define CODE_PHASE_ERR     8'h32
`define CODE_ATN_STOP      8'h42
`define CODE_ATN_STOP_MSG  8'h43
`define CODE_INIT_PH       8'h54
`define CODE_INIT_PH_MSG   8'h55
`define CODE_INIT_PH_STS   8'h56
`define CODE_NONE          8'h00

// SCSI phase encoding as {msg, cd, io}.
`define PH_DATA_OUT        3'h0
`define PH_DATA_IN         3'h1
`define PH_STATUS          3'h3
`define PH_MSG_OUT         3'h6
`define PH_MSG_IN          3'h7

// Longest REQ/ACK period, in controller clocks, that the receiver cannot keep pace with.
`define MIN_PERIOD_CYC     8'h02

`endif

// file: hw/irq_code_pkg.sv
// Types shared by the transfer interrupt encoder.
package irq_code_pkg;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_XFER     = 3'b001,
		ST_MISMATCH = 3'b010,
		ST_MSG_WAIT = 3'b011,
		ST_STS_WAIT = 3'b100,
		ST_DIN_TAKE = 3'b101,
		ST_STOP_MSG = 3'b110
	} seq_state_t;

endpackage

// file: hw/sync2.sv
// Two flip-flop synchroniser for a bundle of pin levels.
module sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule

// file: hw/sync_monitor.sv
// Synchronous offset and REQ/ACK period checker.
`include "irq_code_consts.svh"
module sync_monitor (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// Transfer control
	input  wire logic       active,
	input  wire logic [4:0] offset_limit,
	// Handshake events
	input  wire logic       req_edge,
	input  wire logic       ack_edge,
	// Results
	output logic            offset_err,
	output logic            period_err
);

	logic [5:0] outstanding;
	logic [7:0] gap;

	// Outstanding count rises on each REQ and falls on each ACK sent back.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			outstanding <= 6'h00;
		end else if (!active) begin
			outstanding <= 6'h00;
		end else if (req_edge && !ack_edge) begin
			outstanding <= outstanding + 6'h01;
		end else if (ack_edge && !req_edge && outstanding != 6'h00) begin
			outstanding <= outstanding - 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gap <= 8'hFF;
		end else if (!active || req_edge) begin
			gap <= 8'h00;
		end else if (gap != 8'hFF) begin
			gap <= gap + 8'h01;
		end
	end

	assign offset_err = active && req_edge && (outstanding >= {1'b0, offset_limit});
	assign period_err = active && req_edge && (gap < `MIN_PERIOD_CYC);

endmodule

// file: hw/xfer_irq_encoder.sv
// Transfer and phase-transition interrupt code encoder of the protocol_controller.
//
// Operation
// - SCSI-side parity fault in current phase gives code 24h.
// - Host-side parity fault in programmed data phase gives code 22h.
// - DMA-side parity fault in DMA data phase gives code 21h.
// - Host and SCSI parity faults together give code 26h.
// - DMA and SCSI parity faults together give code 25h.
// - More outstanding synchronous REQs than offset gives code 29h.
// - Synchronous REQ period too short gives code 2Ah.
// - Offset and short period together give code 2Bh.
// - REQ/ACK wait beyond programmed timeout gives code 2Ch.
// - Bus free during a transfer gives code 31h.
// - Unexpected phase change during a transfer gives code 32h.
// - First REQ phase differing from command phase gives code 54h.
// - Mismatch then one message-in byte gives code 55h.
// - Mismatch then one status byte gives code 56h.
// - Attention blocking a phase transition gives code 42h.
// - Data phase halting at block boundary, holding register empty, gives 42h.
// - Attention or boundary stop then one message-out byte gives code 43h.
// - Mismatch with data-in, asynchronous: accept exactly one byte.
// - Mismatch with data-in, synchronous: take bytes per REQ, no ACK.
// - Codes 55h, 56h, 43h only with automatic receive mode on.
// - Code 42h only with automatic receive mode off.
`include "irq_code_consts.svh"
module xfer_irq_encoder
	import irq_code_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// SCSI bus pins
	input  wire logic       scsi_req,
	input  wire logic       scsi_bsy,
	input  wire logic       scsi_sel,
	input  wire logic       scsi_atn,
	input  wire logic [2:0] scsi_phase,
	// Command control from the sequencer
	input  wire logic       cmd_start,
	input  wire logic [2:0] cmd_phase,
	input  wire logic       cmd_done,
	input  wire logic       dma_mode,
	input  wire logic       sync_mode,
	input  wire logic [4:0] offset_limit,
	input  wire logic [15:0] timeout_limit,
	input  wire logic       auto_receive,
	// Data path status
	input  wire logic       ack_sent,
	input  wire logic       byte_taken,
	input  wire logic       scsi_par_err,
	input  wire logic       mpu_par_err,
	input  wire logic       dma_par_err,
	input  wire logic       block_boundary,
	input  wire logic       data_reg_empty,
	// Handshake control back to the sequencer
	output logic            ack_inhibit,
	output logic            accept_byte,
	// Host side
	input  wire logic       code_read,
	output logic [7:0]      irq_code,
	output logic            irq_req
);

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [6:0] pins_s;
	logic       req_s;
	logic       bsy_s;
	logic       sel_s;
	logic       atn_s;
	logic [2:0] phase_s;
	logic       req_d;
	logic       req_edge;

	sync2 #(.WIDTH(7)) u_pin_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.din     ({scsi_req, scsi_bsy, scsi_sel, scsi_atn, scsi_phase}),
		.dout    (pins_s)
	);

	assign {req_s, bsy_s, sel_s, atn_s, phase_s} = pins_s;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			req_d <= 1'b0;
		end else begin
			req_d <= req_s;
		end
	end

	assign req_edge = req_s && !req_d;

	// ----------------------------------------------------------------
	// Sequence state
	// ----------------------------------------------------------------
	seq_state_t state;
	seq_state_t next_state;
	logic       first_req_seen;
	logic       phase_mismatch;
	logic       bus_free;
	logic       atn_block;
	logic       boundary_stop;
	logic       in_data_phase;
	logic       offset_err;
	logic       period_err;
	logic       timed_out;
	logic [15:0] wait_cnt;
	logic       din_byte_done;

	assign bus_free       = !bsy_s && !sel_s;
	assign in_data_phase  = (cmd_phase == `PH_DATA_OUT) || (cmd_phase == `PH_DATA_IN);
	assign phase_mismatch = req_edge && (phase_s != cmd_phase);
	assign atn_block      = atn_s && cmd_done;
	assign boundary_stop  = in_data_phase && block_boundary && data_reg_empty;

	sync_monitor u_sync_mon (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.active       ((state == ST_XFER) && sync_mode),
		.offset_limit (offset_limit),
		.req_edge     (req_edge),
		.ack_edge     (ack_sent),
		.offset_err   (offset_err),
		.period_err   (period_err)
	);

	// Waiting time for the next REQ while a transfer runs.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wait_cnt <= 16'h0000;
		end else if (state != ST_XFER || req_edge) begin
			wait_cnt <= 16'h0000;
		end else if (wait_cnt != 16'hFFFF) begin
			wait_cnt <= wait_cnt + 16'h0001;
		end
	end

	assign timed_out = (timeout_limit != 16'h0000) && (wait_cnt == timeout_limit);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			first_req_seen <= 1'b0;
		end else if (cmd_start) begin
			first_req_seen <= 1'b0;
		end else if (state == ST_XFER && req_edge) begin
			first_req_seen <= 1'b1;
		end
	end

	// One data byte closes the mismatch hold in asynchronous mode only.
	assign din_byte_done = !sync_mode && byte_taken;

	// ----------------------------------------------------------------
	// Event selection
	// ----------------------------------------------------------------
	logic       event_hit;
	logic [7:0] event_code;

	function automatic logic [7:0] parity_code(input logic scsi_e, input logic side_e,
		input logic dma);
		if (scsi_e && side_e) begin
			parity_code = dma ? `CODE_SCSI_DMA_PAR : `CODE_SCSI_MPU_PAR;
		end else if (side_e) begin
			parity_code = dma ? `CODE_DMA_PAR : `CODE_MPU_PAR;
		end else begin
			parity_code = `CODE_SCSI_PAR;
		end
	endfunction

	always_comb begin
		next_state = state;
		event_hit  = 1'b0;
		event_code = `CODE_NONE;
		case (state)
			ST_IDLE: begin
				if (cmd_start) begin
					next_state = ST_XFER;
				end
			end
			ST_XFER: begin
				if (bus_free) begin
					event_hit  = 1'b1;
					event_code = `CODE_BUS_FREE;
					next_state = ST_IDLE;
				end else if (scsi_par_err ||
					(in_data_phase && (dma_mode ? dma_par_err : mpu_par_err))) begin
					event_hit  = 1'b1;
					event_code = parity_code(scsi_par_err,
						in_data_phase && (dma_mode ? dma_par_err : mpu_par_err), dma_mode);
					next_state = ST_IDLE;
				end else if (offset_err || period_err) begin
					event_hit  = 1'b1;
					event_code = (offset_err && period_err) ? `CODE_OFFSET_SHORT :
						(offset_err ? `CODE_OFFSET : `CODE_SHORT_PERIOD);
					next_state = ST_IDLE;
				end else if (timed_out) begin
					event_hit  = 1'b1;
					event_code = `CODE_REQACK_TMO;
					next_state = ST_IDLE;
				end else if (phase_mismatch && !first_req_seen) begin
					if (auto_receive && phase_s == `PH_MSG_IN) begin
						next_state = ST_MSG_WAIT;
					end else if (auto_receive && phase_s == `PH_STATUS) begin
						next_state = ST_STS_WAIT;
					end else if (phase_s == `PH_DATA_IN) begin
						next_state = ST_DIN_TAKE;
					end else begin
						event_hit  = 1'b1;
						event_code = `CODE_INIT_PH;
						next_state = ST_IDLE;
					end
				end else if (phase_mismatch) begin
					event_hit  = 1'b1;
					event_code = `CODE_PHASE_ERR;
					next_state = ST_IDLE;
				end else if (atn_block || boundary_stop) begin
					if (auto_receive) begin
						next_state = ST_STOP_MSG;
					end else begin
						event_hit  = 1'b1;
						event_code = `CODE_ATN_STOP;
						next_state = ST_IDLE;
					end
				end else if (cmd_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_MSG_WAIT: begin
				if (byte_taken) begin
					event_hit  = 1'b1;
					event_code = `CODE_INIT_PH_MSG;
					next_state = ST_IDLE;
				end
			end
			ST_STS_WAIT: begin
				if (byte_taken) begin
					event_hit  = 1'b1;
					event_code = `CODE_INIT_PH_STS;
					next_state = ST_IDLE;
				end
			end
			ST_DIN_TAKE: begin
				if (din_byte_done || (sync_mode && bus_free)) begin
					event_hit  = 1'b1;
					event_code = `CODE_INIT_PH;
					next_state = ST_IDLE;
				end else if (sync_mode && phase_s != `PH_DATA_IN) begin
					event_hit  = 1'b1;
					event_code = `CODE_INIT_PH;
					next_state = ST_IDLE;
				end
			end
			ST_STOP_MSG: begin
				if (byte_taken && phase_s == `PH_MSG_OUT) begin
					event_hit  = 1'b1;
					event_code = `CODE_ATN_STOP_MSG;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Byte intake after an initial mismatch
	// ----------------------------------------------------------------
	// Synchronous data-in is drained one byte per REQ with ACK held off, so the
	// target's offset window fills and the bus stalls instead of losing data.
	// The REQ pulse that reveals the mismatch carries a byte as well, so it is taken too.
	assign accept_byte = ((state == ST_DIN_TAKE) && (sync_mode ? req_edge : req_s)) ||
		(sync_mode && state == ST_XFER && next_state == ST_DIN_TAKE);
	assign ack_inhibit = sync_mode &&
		((state == ST_DIN_TAKE) || (state == ST_XFER && next_state == ST_DIN_TAKE));

	// ----------------------------------------------------------------
	// Host-visible code
	// ----------------------------------------------------------------
	// A new event in the read cycle wins so that it is not lost.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_code <= `CODE_NONE;
			irq_req  <= 1'b0;
		end else if (event_hit) begin
			irq_code <= event_code;
			irq_req  <= 1'b1;
		end else if (code_read) begin
			irq_req  <= 1'b0;
		end
	end

endmodule

// file: verification/xfer_irq_encoder_properties.sv
// Port-level assertions for the transfer interrupt encoder.
module xfer_irq_encoder_properties (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       resetn,
	// Watched ports
	input wire logic       dma_mode,
	input wire logic       sync_mode,
	input wire logic       auto_receive,
	input wire logic       scsi_par_err,
	input wire logic       mpu_par_err,
	input wire logic       dma_par_err,
	input wire logic       code_read,
	input wire logic       ack_inhibit,
	input wire logic [7:0] irq_code,
	input wire logic       irq_req
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	a_scsi_par_code: assert property (
		$changed(irq_code) && irq_code == 8'h24 |-> $past(scsi_par_err)) else $error("bad 24");
	a_mpu_par_code: assert property (
		$changed(irq_code) && irq_code == 8'h22 |-> $past(mpu_par_err) && !$past(dma_mode))
		else $error("bad 22");
	a_dma_par_code: assert property (
		$changed(irq_code) && irq_code == 8'h21 |-> $past(dma_par_err) && $past(dma_mode))
		else $error("bad 21");
	a_mpu_both_code: assert property (
		$changed(irq_code) && irq_code == 8'h26 |-> $past(mpu_par_err) && $past(scsi_par_err))
		else $error("bad 26");
	a_dma_both_code: assert property (
		$changed(irq_code) && irq_code == 8'h25 |-> $past(dma_par_err) && $past(scsi_par_err))
		else $error("bad 25");
	a_inhibit_sync_only: assert property (ack_inhibit |-> sync_mode)
		else $error("ack held off outside synchronous mode");
	a_auto_codes: assert property (
		$changed(irq_code) && irq_code inside {8'h55, 8'h56, 8'h43} |-> $past(auto_receive))
		else $error("automatic receive code with mode off");
	a_stop_manual: assert property (
		$changed(irq_code) && irq_code == 8'h42 |-> !$past(auto_receive)) else $error("bad 42");
	a_req_held: assert property (irq_req && !code_read |=> irq_req)
		else $error("request dropped before the host read");
endmodule

// file: verification/scsi_target_model.sv
// Behavioural SCSI target driving the bus lines seen by the encoder.
module scsi_target_model (
	// Clock
	input  wire logic       ref_clk,
	// Bench control
	input  wire logic       bsy_on,
	input  wire logic       atn_on,
	input  wire logic [2:0] phase_set,
	input  wire logic       go,
	input  wire logic [2:0] n_req,
	input  wire logic [3:0] gap,
	// Bus lines, active high
	output logic            scsi_req,
	output logic            scsi_bsy,
	output logic            scsi_sel,
	output logic            scsi_atn,
	output logic [2:0]      scsi_phase
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] left = 3'h0;
	logic [3:0] cnt = 4'h0;
	logic       req_q = 1'h0;
	// Released lines return to the terminator level, which reads as deasserted.
	assign scsi_req   = req_q & bsy_on;
	assign scsi_bsy   = bsy_on;
	assign scsi_sel   = 1'h0;
	assign scsi_atn   = atn_on & bsy_on;
	assign scsi_phase = bsy_on ? phase_set : 3'h0;
	// Each REQ is high and low for gap+1 clocks, so gap sets the pace.
	always_ff @(posedge ref_clk) begin
		if (go) begin
			left <= n_req;
			cnt <= 4'h0;
			req_q <= 1'h0;
		end else if (left != 3'h0) begin
			cnt <= cnt + 4'h1;
			if (cnt == gap) begin
				cnt <= 4'h0;
				req_q <= ~req_q;
				if (req_q) begin
					left <= left - 3'h1;
				end
			end
		end
	end
endmodule

// file: verification/xfer_irq_encoder_tb_top.sv
// Self-checking bench for the transfer interrupt encoder.
`include "irq_code_consts.svh"
module xfer_irq_encoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'h0, resetn = 1'h0;
	logic        cmd_start = 1'h0, cmd_done = 1'h0, code_read = 1'h0;
	logic        dma_mode = 1'h0, sync_mode = 1'h0, auto_receive = 1'h0;
	logic        ack_sent = 1'h0, byte_taken = 1'h0, go = 1'h0;
	logic        scsi_par_err = 1'h0, mpu_par_err = 1'h0, dma_par_err = 1'h0;
	logic        block_boundary = 1'h0, data_reg_empty = 1'h1, bsy_on = 1'h0, atn_on = 1'h0;
	logic [2:0]  cmd_phase = 3'h0, phase_set = 3'h0, n_req = 3'h0, scsi_phase;
	logic [4:0]  offset_limit = 5'h1F;
	logic [3:0]  req_gap = 4'h2;
	logic [15:0] timeout_limit = 16'h0000;
	logic        scsi_req, scsi_bsy, scsi_sel, scsi_atn, ack_inhibit, accept_byte, irq_req;
	logic [7:0]  irq_code;
	int          error_cnt = 0, compares = 0;

	always #25 ref_clk = ~ref_clk;

	scsi_target_model i_scsi_target_model (.ref_clk(ref_clk), .bsy_on(bsy_on), .atn_on(atn_on),
		.phase_set(phase_set), .go(go), .n_req(n_req), .gap(req_gap), .scsi_req(scsi_req),
		.scsi_bsy(scsi_bsy), .scsi_sel(scsi_sel), .scsi_atn(scsi_atn), .scsi_phase(scsi_phase));
	xfer_irq_encoder i_xfer_irq_encoder (.ref_clk(ref_clk), .resetn(resetn),
		.scsi_req(scsi_req), .scsi_bsy(scsi_bsy), .scsi_sel(scsi_sel), .scsi_atn(scsi_atn),
		.scsi_phase(scsi_phase), .cmd_start(cmd_start), .cmd_phase(cmd_phase),
		.cmd_done(cmd_done), .dma_mode(dma_mode), .sync_mode(sync_mode),
		.offset_limit(offset_limit), .timeout_limit(timeout_limit), .auto_receive(auto_receive),
		.ack_sent(ack_sent), .byte_taken(byte_taken), .scsi_par_err(scsi_par_err),
		.mpu_par_err(mpu_par_err), .dma_par_err(dma_par_err), .block_boundary(block_boundary),
		.data_reg_empty(data_reg_empty), .ack_inhibit(ack_inhibit), .accept_byte(accept_byte),
		.code_read(code_read), .irq_code(irq_code), .irq_req(irq_req));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Fresh reset each time, so a stuck state cannot leak into the next case.
	task automatic start(input logic [2:0] ph, input logic auto);
		@(posedge ref_clk);
		resetn <= 1'h0;
		bsy_on <= 1'h1;
		atn_on <= 1'h0;
		phase_set <= ph;
		auto_receive <= auto;
		tick(2);
		resetn <= 1'h1;
		tick(4);
		cmd_start <= 1'h1;
		@(posedge ref_clk);
		cmd_start <= 1'h0;
	endtask

	task automatic send_req(input logic [2:0] n);
		go <= 1'h1;
		n_req <= n;
		@(posedge ref_clk);
		go <= 1'h0;
	endtask

	task automatic take_byte();
		byte_taken <= 1'h1;
		@(posedge ref_clk);
		byte_taken <= 1'h0;
	endtask

	task automatic wait_irq(input logic [7:0] exp);
		for (int i = 0; i < 60 && irq_req !== 1'h1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (irq_req !== 1'h1) begin
			error_cnt++;
			report_and_stop();
		end
		check(irq_code, exp);
		tick(3);
		#1;
		check({7'h0, irq_req}, 8'h01);
		@(posedge ref_clk);
		code_read <= 1'h1;
		@(posedge ref_clk);
		code_read <= 1'h0;
		@(posedge ref_clk);
		#1;
		check({7'h0, irq_req}, 8'h00);
		@(posedge ref_clk);
	endtask

	task automatic t_parity();
		logic [11:0] tab [5] = '{12'h424, 12'h222, 12'h921, 12'h626, 12'hD25};
		foreach (tab[i]) begin
			dma_mode <= tab[i][11];
			start(`PH_DATA_OUT, 1'h0);
			tick(2);
			{scsi_par_err, mpu_par_err, dma_par_err} <= tab[i][10:8];
			@(posedge ref_clk);
			{scsi_par_err, mpu_par_err, dma_par_err} <= 3'h0;
			wait_irq(tab[i][7:0]);
		end
		dma_mode <= 1'h0;
	endtask

	task automatic t_bus_free();
		start(`PH_DATA_OUT, 1'h0);
		tick(2);
		bsy_on <= 1'h0;
		wait_irq(`CODE_BUS_FREE);
	endtask

	task automatic t_mismatch();
		logic [11:0] tab [3] = '{12'hF55, 12'hB56, 12'h754};
		foreach (tab[i]) begin
			start(tab[i][10:8], tab[i][11]);
			send_req(3'h1);
			tick(12);
			take_byte();
			wait_irq(tab[i][7:0]);
		end
	endtask

	task automatic t_stop();
		for (int a = 0; a < 2; a++) begin
			start(`PH_DATA_OUT, a[0]);
			atn_on <= 1'h1;
			tick(4);
			cmd_done <= 1'h1;
			@(posedge ref_clk);
			cmd_done <= 1'h0;
			phase_set <= `PH_MSG_OUT;
			tick(4);
			take_byte();
			wait_irq(a[0] ? `CODE_ATN_STOP_MSG : `CODE_ATN_STOP);
		end
	endtask

	task automatic t_timeout();
		timeout_limit <= 16'h0008;
		start(`PH_DATA_OUT, 1'h0);
		send_req(3'h1);
		wait_irq(`CODE_REQACK_TMO);
		timeout_limit <= 16'h0000;
	endtask

	// Synchronous data-in after a mismatch: one take per REQ and ACK held off.
	task automatic t_sync_din();
		logic [7:0] takes = 8'h00;
		logic       inhib = 1'h0;
		sync_mode <= 1'h1;
		start(`PH_DATA_IN, 1'h0);
		send_req(3'h3);
		for (int i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			#1;
			takes += {7'h0, accept_byte === 1'h1};
			inhib |= (ack_inhibit === 1'h1);
		end
		check(takes, 8'h03);
		check({7'h0, inhib}, 8'h01);
	endtask

	task automatic t_phase_err();
		start(`PH_DATA_OUT, 1'h0);
		send_req(3'h1);
		tick(10);
		phase_set <= `PH_DATA_IN;
		tick(3);
		send_req(3'h1);
		wait_irq(`CODE_PHASE_ERR);
	endtask

	task automatic t_boundary();
		start(`PH_DATA_OUT, 1'h0);
		tick(2);
		block_boundary <= 1'h1;
		@(posedge ref_clk);
		block_boundary <= 1'h0;
		wait_irq(`CODE_ATN_STOP);
	endtask

	// REQ edges two clocks apart are too fast for the receiver.
	task automatic t_period();
		req_gap <= 4'h0;
		start(`PH_DATA_OUT, 1'h0);
		send_req(3'h3);
		wait_irq(`CODE_SHORT_PERIOD);
		req_gap <= 4'h2;
	endtask

	task automatic t_offset();
		@(posedge ref_clk);
		offset_limit <= 5'h02;
		start(`PH_DATA_OUT, 1'h0);
		send_req(3'h3);
		wait_irq(`CODE_OFFSET);
	endtask

	initial begin
		tick(12);
		t_parity();
		t_bus_free();
		t_mismatch();
		t_stop();
		t_timeout();
		t_phase_err();
		t_boundary();
		t_sync_din();
		t_period();
		t_offset();
		report_and_stop();
	end
endmodule

bind xfer_irq_encoder xfer_irq_encoder_properties i_xfer_irq_encoder_properties (
	.ref_clk(ref_clk), .resetn(resetn), .dma_mode(dma_mode), .sync_mode(sync_mode),
	.auto_receive(auto_receive), .scsi_par_err(scsi_par_err), .mpu_par_err(mpu_par_err),
	.dma_par_err(dma_par_err), .code_read(code_read), .ack_inhibit(ack_inhibit),
	.irq_code(irq_code), .irq_req(irq_req));
